// *** rtl/ocs_map.svh ***
// timing counts, hysteresis figures and setting defaults for the stage
`ifndef OCS_MAP_SVH
`define OCS_MAP_SVH

// system clock period and the 5 ms processing time base
`define OCS_CLK_PERIOD_NS 25
`define OCS_TIME_BASE_NS 5000000
`define OCS_TICK_CYCLES (`OCS_TIME_BASE_NS / `OCS_CLK_PERIOD_NS)

// release delay: 0 to 150 s in 5 ms steps, default 60 ms
`define OCS_REL_STEP_MS 5
`define OCS_REL_MAX_MS 150000
`define OCS_REL_DEFAULT_MS 60
`define OCS_REL_MAX_STEPS (`OCS_REL_MAX_MS / `OCS_REL_STEP_MS)
`define OCS_REL_DEFAULT_STEPS (`OCS_REL_DEFAULT_MS / `OCS_REL_STEP_MS)

// drop-out threshold is 97 percent of the pick-up level
`define OCS_DROP_PCT 97
`define OCS_FULL_PCT 100

// number of independent stages of the overcurrent function
`define OCS_NUM_STAGES 4

`endif

// *** rtl/ocs_pkg.sv ***
// types shared by the overcurrent stage design
package ocs_pkg;

    // monitored magnitude
    typedef enum logic [1:0] {
        MAG_RMS,
        MAG_TRUE_RMS,
        MAG_PEAK
    } meas_kind_t;

    // node operating mode
    typedef enum logic [2:0] {
        MODE_ON,
        MODE_BLOCKED,
        MODE_TEST,
        MODE_TEST_BLOCKED,
        MODE_OFF
    } node_mode_t;

    // forced stage status
    typedef enum logic [4:0] {
        FRC_NORMAL,
        FRC_START,
        FRC_TRIP,
        FRC_BLOCKED,
        FRC_START_A,
        FRC_START_B,
        FRC_START_C,
        FRC_TRIP_A,
        FRC_TRIP_B,
        FRC_TRIP_C,
        FRC_START_AB,
        FRC_START_BC,
        FRC_START_CA,
        FRC_START_ABC,
        FRC_TRIP_AB,
        FRC_TRIP_BC,
        FRC_TRIP_CA,
        FRC_TRIP_ABC
    } force_t;

endpackage : ocs_pkg

// *** rtl/phase_pickup.sv ***
// pick-up element of one phase with drop-out hysteresis
`timescale 1ns/10ps
`include "ocs_map.svh"

module phase_pickup #(
    parameter int W = 16
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic [W-1:0] mag,
    input wire logic [W-1:0] iset,
    output logic picked
);

    typedef struct packed {
        logic picked;
    } state_t;

    state_t st;
    state_t next_st;
    logic [W+6:0] mag_pct;
    logic [W+6:0] set_pct;
    logic [W+6:0] drop_pct;

    // scaled copies so the 97 percent comparison stays in integers
    assign mag_pct = (W+7)'(mag) * (W+7)'(`OCS_FULL_PCT);
    assign set_pct = (W+7)'(iset) * (W+7)'(`OCS_FULL_PCT);
    assign drop_pct = (W+7)'(iset) * (W+7)'(`OCS_DROP_PCT);

    // pick up above the setting, drop only below 97 percent of it
    always_comb begin
        next_st = st;
        if (tick) begin
            if (!st.picked && mag_pct > set_pct) begin
                next_st.picked = 1'b1;
            end else if (st.picked && mag_pct < drop_pct) begin
                next_st.picked = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign picked = st.picked;

endmodule : phase_pickup

// *** rtl/step_counter.sv ***
// saturating up-counter of 5 ms steps with synchronous clear
`timescale 1ns/10ps

module step_counter #(
    parameter int W = 19
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clr,
    input wire logic inc,
    output logic [W-1:0] value
);

    typedef struct packed {
        logic [W-1:0] value;
    } state_t;

    state_t st;
    state_t next_st;

    // clear wins over a step; stop at the top instead of wrapping
    always_comb begin
        next_st = st;
        if (clr) begin
            next_st.value = '0;
        end else if (inc && st.value != {W{1'b1}}) begin
            next_st.value = st.value + W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign value = st.value;

endmodule : step_counter

// *** rtl/overcurrent_stage_release_timer.sv ***
// one stage of the non-directional overcurrent function
`timescale 1ns/10ps
`include "ocs_map.svh"

module overcurrent_stage_release_timer #(
    parameter int W = 16,
    parameter int CW = 19,
    parameter int RW = 15,
    parameter int TICK_CYCLES = `OCS_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    // per-phase magnitudes of both measurement sides
    input wire logic [2:0][W-1:0] side1_rms,
    input wire logic [2:0][W-1:0] side1_true_rms_magnitude,
    input wire logic [2:0][W-1:0] side1_peak,
    input wire logic [2:0][W-1:0] side2_rms,
    input wire logic [2:0][W-1:0] side2_true_rms_magnitude,
    input wire logic [2:0][W-1:0] side2_peak,
    // group settings, followed live except curve_is_log and dial_below_limit, which nothing reads
    input wire logic [W-1:0] iset_local,
    input wire logic [W-1:0] iset_remote,
    input wire logic delayed_release,
    input wire logic [RW-1:0] release_delay,
    input wire logic reset_after_release,
    input wire logic continue_in_release,
    input wire logic signed [CW:0] op_delay,
    input wire logic curve_is_log,
    input wire logic dial_below_limit,
    input wire logic block_in,
    // general settings, taken only on general_load
    input wire logic general_load,
    input wire ocs_pkg::meas_kind_t meas_kind,
    input wire logic meas_side2,
    input wire logic remote_allowed,
    input wire logic node_mode_permitted,
    input wire ocs_pkg::node_mode_t node_mode_set,
    input wire logic forcing_enable,
    input wire ocs_pkg::force_t force_status,
    // stage status
    output logic start,
    output logic trip,
    output logic blocked,
    output logic [2:0] start_phase,
    output logic [2:0] trip_phase,
    output logic time_base_tick,
    output ocs_pkg::node_mode_t node_operating_mode
);

    localparam int TW = $clog2(TICK_CYCLES + 1);

    typedef struct packed {
        logic [TW-1:0] tick_cnt;
        logic tick;
        ocs_pkg::meas_kind_t kind;
        logic side2;
        logic remote;
        ocs_pkg::node_mode_t mode;
        logic force_en;
        ocs_pkg::force_t force_val;
        logic [2:0][W-1:0] mag;
        logic was_active;
        logic releasing;
        logic start;
        logic trip;
        logic blocked;
        logic [2:0] start_ph;
        logic [2:0] trip_ph;
    } state_t;

    state_t st;
    state_t next_st;

    logic [2:0] picked;
    logic [W-1:0] iset;
    logic [CW-1:0] op_val;
    logic [RW-1:0] rel_val;
    logic op_clr;
    logic op_inc;
    logic rel_clr;
    logic rel_inc;
    logic [CW-1:0] delay_eff;
    logic [2:0][W-1:0] sel_rms;
    logic [2:0][W-1:0] sel_true;
    logic [2:0][W-1:0] sel_peak;

    ////////////////////////////////////////////////////////////////////////
    // measurement selection and pick-up elements

    // side selection, then magnitude kind
    assign sel_rms = st.side2 ? side2_rms : side1_rms;
    assign sel_true = st.side2 ? side2_true_rms_magnitude
                               : side1_true_rms_magnitude;
    assign sel_peak = st.side2 ? side2_peak : side1_peak;

    // remote pick-up level only when the general setting allows it
    assign iset = st.remote ? iset_remote : iset_local;

    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++) begin : g_phase
            phase_pickup #(
                .W(W)
            ) u_pickup (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .tick(st.tick),
                .mag(st.mag[ph]),
                .iset(iset),
                .picked(picked[ph])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // operating-time and release counters, in 5 ms steps

    step_counter #(
        .W(CW)
    ) u_op_count (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clr(op_clr),
        .inc(op_inc),
        .value(op_val)
    );

    step_counter #(
        .W(RW)
    ) u_rel_count (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clr(rel_clr),
        .inc(rel_inc),
        .value(rel_val)
    );

    // negative computed delay is taken as instant operation
    always_comb begin
        if (op_delay[CW]) begin
            delay_eff = '0;
        end else begin
            delay_eff = op_delay[CW-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stage sequencing

    always_comb begin
        logic active;
        logic blk;
        logic pu;
        logic pu_ok;
        logic rel_done;
        logic frc_start;
        logic frc_trip;
        logic frc_blk;
        logic [2:0] frc_sph;
        logic [2:0] frc_tph;
        active = 1'b0;
        blk = 1'b0;
        pu = 1'b0;
        pu_ok = 1'b0;
        rel_done = 1'b0;
        frc_start = 1'b0;
        frc_trip = 1'b0;
        frc_blk = 1'b0;
        frc_sph = 3'h0;
        frc_tph = 3'h0;
        next_st = st;
        op_clr = 1'b0;
        op_inc = 1'b0;
        rel_clr = 1'b0;
        rel_inc = 1'b0;

        // internal 5 ms processing base
        next_st.tick = 1'b0;
        if (st.tick_cnt == TW'(TICK_CYCLES - 1)) begin
            next_st.tick_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + TW'(1);
        end

        // general settings move only on their own load strobe
        if (general_load) begin
            next_st.kind = meas_kind;
            next_st.side2 = meas_side2;
            next_st.remote = remote_allowed;
            next_st.force_en = forcing_enable;
            next_st.force_val = force_status;
            if (node_mode_permitted) begin
                next_st.mode = node_mode_set;
            end
        end

        // sample the selected magnitudes once per time base
        if (st.tick) begin
            case (st.kind)
                ocs_pkg::MAG_RMS: next_st.mag = sel_rms;
                ocs_pkg::MAG_TRUE_RMS: next_st.mag = sel_true;
                ocs_pkg::MAG_PEAK: next_st.mag = sel_peak;
                default: next_st.mag = sel_rms;
            endcase
        end

        // mode and blocking; off clears on the edge that loads it
        active = (next_st.mode != ocs_pkg::MODE_OFF);
        blk = block_in || next_st.mode == ocs_pkg::MODE_BLOCKED
              || next_st.mode == ocs_pkg::MODE_TEST_BLOCKED;
        pu = active && (|picked);
        pu_ok = pu && !blk;
        rel_done = st.releasing && rel_val >= release_delay;

        if (!active) begin
            next_st.was_active = 1'b0;
            next_st.releasing = 1'b0;
            next_st.start = 1'b0;
            next_st.trip = 1'b0;
            next_st.blocked = 1'b0;
            next_st.start_ph = 3'h0;
            next_st.trip_ph = 3'h0;
            op_clr = 1'b1;
            rel_clr = 1'b1;
        end else if (st.tick) begin
            next_st.blocked = pu && blk;
            if (pu_ok) begin
                // pick-up active: count toward trip, stop any release
                next_st.was_active = 1'b1;
                next_st.releasing = 1'b0;
                rel_clr = 1'b1;
                op_inc = 1'b1;
                next_st.start = 1'b1;
                next_st.start_ph = picked;
                next_st.trip = op_val >= delay_eff;
                next_st.trip_ph = (op_val >= delay_eff) ? picked : 3'h0;
            end else begin
                // pick-up gone or blocked: release handling
                next_st.trip = 1'b0;
                next_st.trip_ph = 3'h0;
                if (st.was_active) begin
                    next_st.was_active = 1'b0;
                    next_st.releasing = 1'b1;
                    rel_clr = 1'b1;
                end else if (rel_done) begin
                    next_st.releasing = 1'b0;
                    rel_clr = 1'b1;
                end else if (st.releasing) begin
                    rel_inc = 1'b1;
                end
                // start hold follows the release timer only if delayed
                if (delayed_release && (st.was_active
                    || (st.releasing && !rel_done))) begin
                    next_st.start = 1'b1;
                end else begin
                    next_st.start = 1'b0;
                    next_st.start_ph = 3'h0;
                end
                // operating counter across the release time
                if (st.trip) begin
                    op_clr = 1'b1;
                end else if (!reset_after_release) begin
                    op_clr = 1'b1;
                end else if (rel_done) begin
                    op_clr = 1'b1;
                end else if (continue_in_release
                             && (st.was_active || st.releasing)) begin
                    op_inc = 1'b1;
                end
            end
        end

        // forced status is merged with measured status on each tick
        if (st.force_en && st.tick && active) begin
            case (st.force_val)
                ocs_pkg::FRC_NORMAL: frc_start = 1'b0;
                ocs_pkg::FRC_START: frc_start = 1'b1;
                ocs_pkg::FRC_TRIP: frc_trip = 1'b1;
                ocs_pkg::FRC_BLOCKED: frc_blk = 1'b1;
                ocs_pkg::FRC_START_A: frc_sph = 3'h1;
                ocs_pkg::FRC_START_B: frc_sph = 3'h2;
                ocs_pkg::FRC_START_C: frc_sph = 3'h4;
                ocs_pkg::FRC_TRIP_A: frc_tph = 3'h1;
                ocs_pkg::FRC_TRIP_B: frc_tph = 3'h2;
                ocs_pkg::FRC_TRIP_C: frc_tph = 3'h4;
                ocs_pkg::FRC_START_AB: frc_sph = 3'h3;
                ocs_pkg::FRC_START_BC: frc_sph = 3'h6;
                ocs_pkg::FRC_START_CA: frc_sph = 3'h5;
                ocs_pkg::FRC_START_ABC: frc_sph = 3'h7;
                ocs_pkg::FRC_TRIP_AB: frc_tph = 3'h3;
                ocs_pkg::FRC_TRIP_BC: frc_tph = 3'h6;
                ocs_pkg::FRC_TRIP_CA: frc_tph = 3'h5;
                ocs_pkg::FRC_TRIP_ABC: frc_tph = 3'h7;
                default: frc_start = 1'b0;
            endcase
        end
        frc_start = frc_start || (|frc_sph);
        frc_trip = frc_trip || (|frc_tph);
        next_st.start_ph = next_st.start_ph | frc_sph | frc_tph;
        next_st.trip_ph = next_st.trip_ph | frc_tph;
        if (st.force_en) begin
            // forced values are re-applied each tick, measured ones kept
            if (frc_start || frc_trip) begin
                next_st.start = 1'b1;
            end
            if (frc_trip) begin
                next_st.trip = 1'b1;
            end
            if (frc_blk) begin
                next_st.blocked = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= '0;
            st.kind <= ocs_pkg::MAG_RMS;
            st.mode <= ocs_pkg::MODE_ON;
            st.force_val <= ocs_pkg::FRC_NORMAL;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, each straight from the state register

    // one instance per stage; the function uses four of them
    assign start = st.start;
    assign trip = st.trip;
    assign blocked = st.blocked;
    assign start_phase = st.start_ph;
    assign trip_phase = st.trip_ph;
    assign time_base_tick = st.tick;
    assign node_operating_mode = st.mode;

endmodule : overcurrent_stage_release_timer

// *** verification/ocs_stage_properties.sv ***
// concurrent checks on the ports of one overcurrent stage
`timescale 1ns/10ps

module ocs_stage_properties #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic general_load,
    input wire logic node_mode_permitted,
    input wire ocs_pkg::node_mode_t node_mode_set,
    input wire logic start,
    input wire logic trip,
    input wire logic blocked,
    input wire logic [2:0] start_phase,
    input wire logic [2:0] trip_phase,
    input wire logic time_base_tick,
    input wire ocs_pkg::node_mode_t node_operating_mode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    logic [31:0] gap;
    logic gap_valid;

    ////////////////////////////////////////////////////////////////////////
    // cycles since the last time base pulse
    always_ff @(posedge clk_sys) begin
        if (sys_rst || time_base_tick) begin
            gap <= 32'h0;
        end else begin
            gap <= gap + 32'h1;
        end
        if (sys_rst) begin
            gap_valid <= 1'b0;
        end else if (time_base_tick) begin
            gap_valid <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    reset_clear_a: assert property (disable iff (1'b0) sys_rst |=>
        !start && !trip && !blocked
        && node_operating_mode == ocs_pkg::MODE_ON)
        else $error("outputs not cleared by reset");
    tick_period_a: assert property ((gap_valid && time_base_tick) |->
        gap == TICK_CYCLES - 1)
        else $error("time base pulse spacing wrong");
    tick_late_a: assert property (gap_valid |-> gap < TICK_CYCLES)
        else $error("time base pulse missing");
    start_on_tick_a: assert property ($changed(start) |->
        $past(time_base_tick) || node_operating_mode == ocs_pkg::MODE_OFF)
        else $error("start changed away from a time base pulse");
    phase_summary_a: assert property ((|start_phase |-> start)
        and (|trip_phase |-> trip))
        else $error("phase status without summary status");
    trip_subset_a: assert property ((trip_phase & ~start_phase) == 3'h0)
        else $error("phase trips without phase start");
    off_quiet_a: assert property (
        node_operating_mode == ocs_pkg::MODE_OFF |-> !start && !trip && !blocked)
        else $error("activity while node mode is off");
    mode_refused_a: assert property (
        general_load && !node_mode_permitted |=> $stable(node_operating_mode))
        else $error("node mode changed without permission");
    mode_taken_a: assert property (
        general_load && node_mode_permitted |=>
        node_operating_mode == $past(node_mode_set))
        else $error("permitted node mode not taken");

    cover property ($rose(trip));
    cover property ($fell(start));
    cover property (blocked);
    cover property (node_operating_mode == ocs_pkg::MODE_OFF);
endmodule : ocs_stage_properties

// *** verification/overcurrent_stage_release_timer_tb.sv ***
// self-checking bench for one overcurrent stage
`timescale 1ns/10ps

module overcurrent_stage_release_timer_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0][15:0] s1_rms = '0;
    logic [2:0][15:0] s1_true = '0;
    logic [2:0][15:0] s1_peak = '0;
    logic [2:0][15:0] s2_rms = '0;
    logic [2:0][15:0] s2_true = '0;
    logic [2:0][15:0] s2_peak = '0;
    logic [15:0] iset_remote = 16'h0064;
    logic delayed_release = 1'b1;
    logic [14:0] release_delay = 15'h0003;
    logic reset_after_release = 1'b1;
    logic continue_in_release = 1'b0;
    logic signed [19:0] op_delay = 20'sh00003;
    logic curve_is_log = 1'b0;
    logic dial_below_limit = 1'b0;
    logic general_load = 1'b0;
    ocs_pkg::meas_kind_t meas_kind = ocs_pkg::MAG_RMS;
    logic meas_side2 = 1'b0;
    logic remote_allowed = 1'b0;
    logic node_mode_permitted = 1'b0;
    ocs_pkg::node_mode_t node_mode_set = ocs_pkg::MODE_ON;
    logic forcing_enable = 1'b0;
    ocs_pkg::force_t force_status = ocs_pkg::FRC_NORMAL;
    logic start, trip, blocked, time_base_tick;
    logic [2:0] start_phase, trip_phase;
    ocs_pkg::node_mode_t node_operating_mode;
    int n_errors = 0;
    int comparisons = 0;

    always #12.5 clk_sys = ~clk_sys;

    overcurrent_stage_release_timer #(.TICK_CYCLES(4))
        overcurrent_stage_release_timer_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .side1_rms(s1_rms), .side1_true_rms_magnitude(s1_true),
        .side1_peak(s1_peak), .side2_rms(s2_rms),
        .side2_true_rms_magnitude(s2_true), .side2_peak(s2_peak),
        .iset_local(16'h0064), .iset_remote(iset_remote),
        .delayed_release(delayed_release), .release_delay(release_delay),
        .reset_after_release(reset_after_release),
        .continue_in_release(continue_in_release),
        .op_delay(op_delay), .curve_is_log(curve_is_log),
        .dial_below_limit(dial_below_limit), .block_in(1'b0),
        .general_load(general_load), .meas_kind(meas_kind),
        .meas_side2(meas_side2), .remote_allowed(remote_allowed),
        .node_mode_permitted(node_mode_permitted),
        .node_mode_set(node_mode_set), .forcing_enable(forcing_enable),
        .force_status(force_status), .start(start), .trip(trip),
        .blocked(blocked), .start_phase(start_phase),
        .trip_phase(trip_phase), .time_base_tick(time_base_tick),
        .node_operating_mode(node_operating_mode));

    ////////////////////////////////////////////////////////////////////////
    // compare, count and report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done

    // wait for n time base pulses, then let outputs settle
    task automatic ticks(input int n);
        repeat (n) begin
            do @(negedge clk_sys); while (time_base_tick !== 1'b1);
        end
        @(negedge clk_sys);
    endtask : ticks

    // load the static general settings with one pulse
    task automatic gload(input ocs_pkg::meas_kind_t k, input logic s2,
        input logic ra, input logic perm, input ocs_pkg::node_mode_t m,
        input logic fe, input ocs_pkg::force_t f);
        @(posedge clk_sys);
        meas_kind <= k;
        meas_side2 <= s2;
        remote_allowed <= ra;
        node_mode_permitted <= perm;
        node_mode_set <= m;
        forcing_enable <= fe;
        force_status <= f;
        general_load <= 1'b1;
        @(posedge clk_sys);
        general_load <= 1'b0;
        @(negedge clk_sys);
    endtask : gload

    ////////////////////////////////////////////////////////////////////////
    // pick-up, timed trip, hysteresis and held release
    task automatic t_trip;
        @(posedge clk_sys);
        s1_rms[0] <= 16'h0078;
        ticks(3);
        chk(start, 1);
        chk(start_phase, 3'h1);
        chk(trip, 0);
        ticks(5);
        chk(trip, 1);
        @(posedge clk_sys);
        s1_rms[0] <= 16'h0062; // inside the hysteresis band
        ticks(3);
        chk(start, 1);
        @(posedge clk_sys);
        s1_rms[0] <= 16'h0000;
        ticks(3);
        chk(trip, 0);
        chk(start, 1);
        ticks(5);
        chk(start, 0);
        $display("t_trip done");
    endtask : t_trip

    // negative delay trips at once; no release delay
    task automatic t_instant;
        @(posedge clk_sys);
        delayed_release <= 1'b0;
        op_delay <= '1;
        curve_is_log <= 1'b1;
        dial_below_limit <= 1'b1;
        s1_rms[1] <= 16'h0078;
        s1_rms[2] <= 16'h0078;
        ticks(4);
        chk(trip, 1);
        chk(start_phase, 3'h6);
        @(posedge clk_sys);
        s1_rms <= '0;
        ticks(3);
        chk(start, 0);
        @(posedge clk_sys);
        delayed_release <= 1'b1;
        op_delay <= 20'sh00003;
        $display("t_instant done");
    endtask : t_instant

    // magnitude kind, measurement side and remote level
    task automatic t_select;
        gload(ocs_pkg::MAG_PEAK, 1, 0, 0, ocs_pkg::MODE_ON, 0,
            ocs_pkg::FRC_NORMAL);
        @(posedge clk_sys);
        s1_rms <= {3{16'h0078}};
        ticks(4);
        chk(start, 0);
        @(posedge clk_sys);
        s1_rms <= '0;
        s2_peak[2] <= 16'h0078;
        ticks(4);
        chk(start_phase, 3'h4);
        gload(ocs_pkg::MAG_PEAK, 1, 1, 0, ocs_pkg::MODE_ON, 0,
            ocs_pkg::FRC_NORMAL);
        @(posedge clk_sys);
        iset_remote <= 16'h0200;
        ticks(8);
        chk(start, 0);
        gload(ocs_pkg::MAG_PEAK, 1, 0, 0, ocs_pkg::MODE_ON, 0,
            ocs_pkg::FRC_NORMAL);
        ticks(4);
        chk(start, 1);
        @(posedge clk_sys);
        s2_peak <= '0;
        gload(ocs_pkg::MAG_RMS, 0, 0, 0, ocs_pkg::MODE_ON, 0,
            ocs_pkg::FRC_NORMAL);
        ticks(8);
        $display("t_select done");
    endtask : t_select

    // forced status alongside measured pick-up
    task automatic t_force;
        gload(ocs_pkg::MAG_RMS, 0, 0, 0, ocs_pkg::MODE_ON, 1,
            ocs_pkg::FRC_TRIP);
        ticks(2);
        chk(trip, 1);
        gload(ocs_pkg::MAG_RMS, 0, 0, 0, ocs_pkg::MODE_ON, 1,
            ocs_pkg::FRC_START_CA);
        ticks(2);
        chk(start_phase, 3'h5);
        gload(ocs_pkg::MAG_RMS, 0, 0, 0, ocs_pkg::MODE_ON, 1,
            ocs_pkg::FRC_NORMAL);
        @(posedge clk_sys);
        s1_rms[1] <= 16'h0078;
        ticks(4);
        chk(start_phase, 3'h2);
        @(posedge clk_sys);
        s1_rms <= '0;
        gload(ocs_pkg::MAG_RMS, 0, 0, 0, ocs_pkg::MODE_ON, 0,
            ocs_pkg::FRC_NORMAL);
        ticks(8);
        chk(start, 0);
        $display("t_force done");
    endtask : t_force

    // node mode permission, blocked and off
    task automatic t_mode;
        gload(ocs_pkg::MAG_RMS, 0, 0, 0, ocs_pkg::MODE_OFF, 0,
            ocs_pkg::FRC_NORMAL);
        chk(node_operating_mode, ocs_pkg::MODE_ON);
        gload(ocs_pkg::MAG_RMS, 0, 0, 1, ocs_pkg::MODE_BLOCKED, 0,
            ocs_pkg::FRC_NORMAL);
        @(posedge clk_sys);
        s1_rms[0] <= 16'h0078;
        ticks(4);
        chk(blocked, 1);
        chk(start, 0);
        gload(ocs_pkg::MAG_RMS, 0, 0, 1, ocs_pkg::MODE_OFF, 0,
            ocs_pkg::FRC_NORMAL);
        chk(node_operating_mode, ocs_pkg::MODE_OFF);
        chk(blocked, 0);
        @(posedge clk_sys);
        s1_rms <= '0;
        gload(ocs_pkg::MAG_RMS, 0, 0, 1, ocs_pkg::MODE_ON, 0,
            ocs_pkg::FRC_NORMAL);
        ticks(8);
        $display("t_mode done");
    endtask : t_mode

    // renewed pick-up inside the release time, counter kept or cleared
    task automatic t_release(input logic rar, input logic cont,
        input logic signed [19:0] dly, input logic exp);
        @(posedge clk_sys);
        reset_after_release <= rar;
        continue_in_release <= cont;
        op_delay <= dly;
        s1_rms[0] <= 16'h0078;
        ticks(3);
        @(posedge clk_sys);
        s1_rms[0] <= 16'h0000;
        ticks(2);
        @(posedge clk_sys);
        s1_rms[0] <= 16'h0078;
        ticks(2);
        chk(trip, 0);
        ticks(1);
        chk(trip, exp);
        @(posedge clk_sys);
        s1_rms[0] <= 16'h0000;
        ticks(8);
        $display("t_release done");
    endtask : t_release

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        chk(node_operating_mode, ocs_pkg::MODE_ON);
        t_trip();
        t_instant();
        t_select();
        t_force();
        t_mode();
        t_release(1'b1, 1'b1, 20'sh00005, 1'b1);
        t_release(1'b1, 1'b0, 20'sh00003, 1'b1);
        t_release(1'b0, 1'b0, 20'sh00003, 1'b0);
        test_done();
    end

    // watchdog: fires after 20000 cycles; the run needs well under that
    initial begin
        #(25 * 20000);
        n_errors++;
        test_done();
    end
endmodule : overcurrent_stage_release_timer_tb

bind overcurrent_stage_release_timer ocs_stage_properties #(
    .TICK_CYCLES(TICK_CYCLES)) ocs_stage_properties_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .general_load(general_load),
    .node_mode_permitted(node_mode_permitted),
    .node_mode_set(node_mode_set), .start(start), .trip(trip),
    .blocked(blocked), .start_phase(start_phase),
    .trip_phase(trip_phase), .time_base_tick(time_base_tick),
    .node_operating_mode(node_operating_mode));
